//--- hdl/prioritized_interrupt_controller.v
`timescale 1ns/1ps
`include "intc_regs.vh"

module prioritized_interrupt_controller (
    input wire ref_clk_i, // system clock 25 MHz
    input wire rst_i, // async reset, active high
    input wire ce_i, // clock enable, freezes all state when low
    input wire ext_request_high_i, // external high pin, falling edge
    input wire ext_request_low_i, // external low pin, falling edge
    input wire serial_done_request_i, // serial done pulse
    input wire counter1_overflow_request_i, // counter1 overflow pulse
    input wire counter2_overflow_request_i, // counter2 overflow pulse
    input wire interval_tick_request_i, // interval tick pulse
    input wire instr_cycle_i, // one pulse per instruction cycle
    input wire instr_end_i, // current instruction completes
    input wire op_valid_i, // instruction strobe from core
    input wire [2:0] op_code_i, // controller instruction code
    input wire [5:0] op_field_i, // latch hold/clear field
    input wire [3:0] acc_i, // accumulator value for mask swap
    output reg [3:0] acc_o, // old mask returned by swap
    output reg pending_o, // enabled request pending
    output reg [15:0] entry_addr_o, // entry of highest pending source
    output reg ack_busy_o, // acknowledge sequence running
    output reg push_o, // push program counter and flags
    output reg load_pc_o, // load entry_addr_o into program counter
    output reg status_set_o, // set status flag
    output reg pop_o, // pop program counter and flags
    output reg master_enable_o, // master enable flop
    output reg [3:0] source_enable_mask_o, // mask register
    output reg [5:0] request_latch_o // request latches
);

localparam ST_IDLE = 3'h0;
localparam ST_WAIT = 3'h1;
localparam ST_PUSH = 3'h2;
localparam ST_LOAD = 3'h3;
localparam ST_STATUS = 3'h4;
localparam ST_CLR_MEF = 3'h5;
localparam ST_CLR_LATCH = 3'h6;
localparam ST_POP = 3'h7;

reg [5:0] request_latch_reg;
reg [5:0] request_latch_next;
reg master_enable_flop_reg;
reg master_enable_flop_next;
reg [3:0] source_enable_mask_reg;
reg [3:0] source_enable_mask_next;
reg [2:0] state_reg;
reg [2:0] state_next;
reg [1:0] wait_reg;
reg [1:0] wait_next;
reg [2:0] taken_reg;
reg [2:0] taken_next;
reg [15:0] taken_entry_reg;
reg [15:0] taken_entry_next;
reg ret_pend_reg;
reg ret_pend_next;

wire [1:0] ext_fall;
wire [1:0] ext_pin;
wire [5:0] hw_set;
wire [5:0] enabled;
wire pick_any;
wire [2:0] pick_index;
wire [15:0] pick_entry;

assign ext_pin = {ext_request_high_i, ext_request_low_i};

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_ext
        pin_fall_detect u_fall (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .pin_i(ext_pin[g]),
            .fall_o(ext_fall[g])
        );
    end
endgenerate

// hardware set sources per latch
assign hw_set = {ext_fall[1], serial_done_request_i, counter1_overflow_request_i,
                 counter2_overflow_request_i, interval_tick_request_i, ext_fall[0]};

function [5:0] gate_sources;
    input [5:0] lat;
    input mef;
    input [3:0] mask;
    begin
        gate_sources[`LAT_EXT_HIGH] = lat[`LAT_EXT_HIGH] & mef;
        gate_sources[`LAT_SERIAL] = lat[`LAT_SERIAL] & mef & mask[`MASK_SERIAL];
        gate_sources[`LAT_CTR1] = lat[`LAT_CTR1] & mef & mask[`MASK_CTR1];
        gate_sources[`LAT_CTR2] = lat[`LAT_CTR2] & mef & mask[`MASK_CTR2_TICK];
        gate_sources[`LAT_TICK] = lat[`LAT_TICK] & mef & mask[`MASK_CTR2_TICK];
        gate_sources[`LAT_EXT_LOW] = lat[`LAT_EXT_LOW] & mef & mask[`MASK_EXT_LOW];
    end
endfunction

assign enabled = gate_sources(request_latch_reg, master_enable_flop_reg, source_enable_mask_reg);

priority_pick u_pick (
    .req_i(enabled),
    .any_o(pick_any),
    .index_o(pick_index),
    .entry_o(pick_entry)
);

wire op_take = op_valid_i;
wire op_latch_clear = op_take & ((op_code_i == `OP_ENABLE_CLEAR) |
                                 (op_code_i == `OP_DISABLE_CLEAR) |
                                 (op_code_i == `OP_CLEAR_ONLY));

always @* begin
    request_latch_next = request_latch_reg;
    master_enable_flop_next = master_enable_flop_reg;
    source_enable_mask_next = source_enable_mask_reg;
    state_next = state_reg;
    wait_next = wait_reg;
    taken_next = taken_reg;
    taken_entry_next = taken_entry_reg;
    ret_pend_next = ret_pend_reg;

    // field zero clears, one holds; no instruction sets a latch
    if (op_latch_clear) begin
        request_latch_next = request_latch_next & op_field_i;
    end
    if (op_take && op_code_i == `OP_ENABLE_CLEAR) begin
        master_enable_flop_next = 1'b1;
    end
    if (op_take && op_code_i == `OP_DISABLE_CLEAR) begin
        master_enable_flop_next = 1'b0;
    end
    if (op_take && op_code_i == `OP_SWAP_MASK) begin
        source_enable_mask_next = acc_i;
    end
    if (op_take && op_code_i == `OP_RETURN) begin
        ret_pend_next = 1'b1;
    end

    case (state_reg)
        ST_IDLE: begin
            if (ret_pend_reg) begin
                state_next = ST_POP;
            end else if (instr_end_i && pick_any) begin
                state_next = ST_WAIT;
                wait_next = `ACK_DELAY_CYCLES;
            end
        end
        ST_WAIT: begin
            if (!pick_any) begin
                state_next = ST_IDLE;
            end else if (instr_cycle_i) begin
                if (wait_reg == 2'h1) begin
                    state_next = ST_PUSH;
                    taken_next = pick_index;
                    taken_entry_next = pick_entry;
                end
                wait_next = wait_reg - 2'h1;
            end
        end
        ST_PUSH: begin
            state_next = ST_LOAD;
        end
        ST_LOAD: begin
            state_next = ST_STATUS;
        end
        ST_STATUS: begin
            state_next = ST_CLR_MEF;
        end
        ST_CLR_MEF: begin
            master_enable_flop_next = 1'b0;
            state_next = ST_CLR_LATCH;
        end
        ST_CLR_LATCH: begin
            request_latch_next[taken_reg] = 1'b0;
            state_next = ST_IDLE;
        end
        ST_POP: begin
            master_enable_flop_next = 1'b1;
            ret_pend_next = 1'b0;
            state_next = ST_IDLE;
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase

    // a hardware request in the same cycle as a clear is kept
    request_latch_next = request_latch_next | hw_set;
end

always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
        request_latch_reg <= `LATCH_RESET;
        master_enable_flop_reg <= `MEF_RESET;
        source_enable_mask_reg <= `MASK_RESET;
        state_reg <= ST_IDLE;
        wait_reg <= 2'h0;
        taken_reg <= 3'h0;
        taken_entry_reg <= 16'h0000;
        ret_pend_reg <= 1'b0;
        acc_o <= 4'h0;
        pending_o <= 1'b0;
        entry_addr_o <= 16'h0000;
        ack_busy_o <= 1'b0;
        push_o <= 1'b0;
        load_pc_o <= 1'b0;
        status_set_o <= 1'b0;
        pop_o <= 1'b0;
        master_enable_o <= 1'b0;
        source_enable_mask_o <= 4'h0;
        request_latch_o <= 6'h00;
    end else if (ce_i) begin
        request_latch_reg <= request_latch_next;
        master_enable_flop_reg <= master_enable_flop_next;
        source_enable_mask_reg <= source_enable_mask_next;
        state_reg <= state_next;
        wait_reg <= wait_next;
        taken_reg <= taken_next;
        taken_entry_reg <= taken_entry_next;
        ret_pend_reg <= ret_pend_next;
        if (op_take && op_code_i == `OP_SWAP_MASK) begin
            acc_o <= source_enable_mask_reg;
        end
        pending_o <= pick_any;
        entry_addr_o <= (state_next == ST_IDLE || state_next == ST_WAIT) ? pick_entry : taken_entry_next;
        ack_busy_o <= (state_next != ST_IDLE) && (state_next != ST_POP);
        push_o <= (state_next == ST_PUSH);
        load_pc_o <= (state_next == ST_LOAD);
        status_set_o <= (state_next == ST_STATUS);
        pop_o <= (state_next == ST_POP);
        master_enable_o <= master_enable_flop_next;
        source_enable_mask_o <= source_enable_mask_next;
        request_latch_o <= request_latch_next;
    end
end

endmodule // prioritized_interrupt_controller

//--- hdl/intc_regs.vh
`ifndef INTC_REGS_VH
`define INTC_REGS_VH

// request latch indices, 5 is highest priority
`define LAT_EXT_HIGH 3'h5
`define LAT_SERIAL 3'h4
`define LAT_CTR1 3'h3
`define LAT_CTR2 3'h2
`define LAT_TICK 3'h1
`define LAT_EXT_LOW 3'h0
`define LAT_COUNT 6

// source enable mask bit positions
`define MASK_SERIAL 3
`define MASK_CTR1 2
`define MASK_CTR2_TICK 1
`define MASK_EXT_LOW 0
`define MASK_RESET 4'h0

// entry address of the highest source and spacing
`define ENTRY_BASE 16'h0002
`define ENTRY_STEP 16'h0002
`define ENTRY_LOWEST 16'h000C

// core instruction codes seen by the controller
`define OP_NONE 3'h0
`define OP_ENABLE_CLEAR 3'h1
`define OP_DISABLE_CLEAR 3'h2
`define OP_CLEAR_ONLY 3'h3
`define OP_SWAP_MASK 3'h4
`define OP_RETURN 3'h5

// instruction cycles from end of instruction to acknowledge
`define ACK_DELAY_CYCLES 2'h2

`define LATCH_RESET 6'h00
`define MEF_RESET 1'b0

`endif

//--- hdl/pin_fall_detect.v
`timescale 1ns/1ps
`include "intc_regs.vh"

module pin_fall_detect (
    input wire ref_clk_i, // system clock
    input wire rst_i, // async reset, active high
    input wire ce_i, // clock enable
    input wire pin_i, // raw pin level from outside
    output reg fall_o // one-cycle pulse on falling edge
);

reg sync1_reg;
reg sync2_reg;
reg last_reg;

always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sync1_reg <= 1'b1;
        sync2_reg <= 1'b1;
        last_reg <= 1'b1;
        fall_o <= 1'b0;
    end else if (ce_i) begin
        sync1_reg <= pin_i;
        sync2_reg <= sync1_reg;
        last_reg <= sync2_reg;
        fall_o <= last_reg & ~sync2_reg;
    end
end

endmodule // pin_fall_detect

//--- hdl/priority_pick.v
`timescale 1ns/1ps
`include "intc_regs.vh"

module priority_pick (
    input wire [5:0] req_i, // enabled pending latches
    output reg any_o, // at least one request
    output reg [2:0] index_o, // highest pending index
    output reg [15:0] entry_o // entry address of that index
);

integer k;

// lowest index first so the highest set bit wins
always @* begin
    any_o = 1'b0;
    index_o = 3'h0;
    for (k = 0; k < `LAT_COUNT; k = k + 1) begin
        if (req_i[k]) begin
            any_o = 1'b1;
            index_o = k[2:0];
        end
    end
    entry_o = `ENTRY_BASE + `ENTRY_STEP * {13'h0000, `LAT_EXT_HIGH - index_o};
end

endmodule // priority_pick

//--- test/intc_sva.sv
`timescale 1ns/1ps
module intc_sva (
    input wire ref_clk_i, // clk
    input wire rst_i, // reset
    input wire op_valid_i, // strobe
    input wire [2:0] op_code_i, // code
    input wire [5:0] op_field_i, // field
    input wire [3:0] acc_i, // acc in
    input wire [3:0] acc_o, // acc out
    input wire pending_o, // pending
    input wire [15:0] entry_addr_o, // entry
    input wire ack_busy_o, // busy
    input wire push_o, // push
    input wire load_pc_o, // load
    input wire status_set_o, // status
    input wire pop_o, // pop
    input wire master_enable_o, // enable
    input wire [3:0] source_enable_mask_o, // mask
    input wire [5:0] request_latch_o // latches
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    swap_mask_a: assert property (op_valid_i && op_code_i == 3'h4 |=> source_enable_mask_o == $past(acc_i))
        else $error("mask not loaded by swap");
    swap_return_a: assert property (op_valid_i && op_code_i == 3'h4 |=> acc_o == $past(source_enable_mask_o))
        else $error("old mask not returned");
    ack_order_a: assert property (push_o |=> load_pc_o ##1 status_set_o ##2 !master_enable_o)
        else $error("acknowledge order broken");
    ack_disable_a: assert property (status_set_o |=> ##1 !master_enable_o ##1 !ack_busy_o)
        else $error("enable not cleared on accept");
    return_enable_a: assert property (pop_o |=> master_enable_o)
        else $error("return did not enable");
    enable_set_a: assert property (op_valid_i && op_code_i == 3'h1 |=> master_enable_o)
        else $error("enable-clear did not set");
    disable_clr_a: assert property (op_valid_i && op_code_i == 3'h2 |=> !master_enable_o)
        else $error("disable-clear did not clear");
    clear_field_a: assert property (op_valid_i && op_code_i inside {3'h1, 3'h2, 3'h3}
        |=> (request_latch_o & ~$past(op_field_i)) == 6'h00)
        else $error("latch not cleared by field");
    gate_pending_a: assert property (!master_enable_o |=> !pending_o)
        else $error("pending while disabled");
endmodule // intc_sva
bind prioritized_interrupt_controller intc_sva chk (.ref_clk_i, .rst_i, .op_valid_i, .op_code_i, .op_field_i,
    .acc_i, .acc_o, .pending_o, .entry_addr_o, .ack_busy_o, .push_o, .load_pc_o, .status_set_o, .pop_o,
    .master_enable_o, .source_enable_mask_o, .request_latch_o);

//--- test/core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire ref_clk_i, // clk
    input wire rst_i, // reset
    output reg instr_cycle_o, // cycle pulse
    output reg instr_end_o // end pulse
);
    reg [1:0] cnt_reg;
    // two-cycle instructions, one end every four clocks
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 2'h0;
            instr_cycle_o <= 1'b0;
            instr_end_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            instr_cycle_o <= cnt_reg[0];
            instr_end_o <= (cnt_reg == 2'h3);
        end
    end
endmodule // core_model

//--- test/prioritized_interrupt_controller_test.sv
`timescale 1ns/1ps
module prioritized_interrupt_controller_test;
    reg ref_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg op_valid_i = 1'b0;
    reg [2:0] op_code_i = 3'h0;
    reg [5:0] op_field_i = 6'h00;
    reg [3:0] acc_i = 4'h0;
    reg [5:0] src = 6'h00;
    reg [31:0] seed = 32'hB8B0AECB;
    reg [3:0] m;
    integer n_fail = 0;
    integer tests_run = 0;
    integer k, i, w;
    wire instr_cycle_i, instr_end_i, pending_o, ack_busy_o, push_o, load_pc_o, status_set_o, pop_o;
    wire master_enable_o;
    wire [3:0] acc_o, source_enable_mask_o;
    wire [15:0] entry_addr_o;
    wire [5:0] request_latch_o;
    always #20 ref_clk_i = ~ref_clk_i;
    core_model cpu (.ref_clk_i, .rst_i, .instr_cycle_o(instr_cycle_i), .instr_end_o(instr_end_i));
    prioritized_interrupt_controller dut (.ref_clk_i, .rst_i, .ce_i(1'b1), .ext_request_high_i(~src[5]),
        .ext_request_low_i(~src[0]), .serial_done_request_i(src[4]), .counter1_overflow_request_i(src[3]),
        .counter2_overflow_request_i(src[2]), .interval_tick_request_i(src[1]), .instr_cycle_i, .instr_end_i,
        .op_valid_i, .op_code_i, .op_field_i, .acc_i, .acc_o, .pending_o, .entry_addr_o, .ack_busy_o, .push_o,
        .load_pc_o, .status_set_o, .pop_o, .master_enable_o, .source_enable_mask_o, .request_latch_o);
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [3:0] mask_for(input integer j);
        mask_for = (j == 4) ? 4'h8 : (j == 3) ? 4'h4 : (j == 0) ? 4'h1 : (j == 5) ? 4'h0 : 4'h2;
    endfunction
    task test_done;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task op(input [2:0] c, input [5:0] f, input [3:0] a);
        begin
            @(negedge ref_clk_i);
            op_valid_i = 1'b1;
            op_code_i = c;
            op_field_i = f;
            acc_i = a;
            @(negedge ref_clk_i);
            op_valid_i = 1'b0;
        end
    endtask
    task raise(input integer j);
        begin
            @(negedge ref_clk_i);
            src[j] = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            src[j] = 1'b0;
        end
    endtask
    // 0 push, 1 pop, 2 latch k set
    task wait_on(input integer s);
        begin
            w = 0;
            while (!(s == 0 ? push_o : s == 1 ? pop_o : request_latch_o[k]) && w < 60) begin
                @(posedge ref_clk_i);
                #1 w = w + 1;
            end
            if (w >= 60) begin
                n_fail = n_fail + 1;
                test_done;
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i) rst_i = 1'b0;
        chk("mask", 16'h0, source_enable_mask_o);
        chk("enable", 16'h0, master_enable_o);
        chk("latch", 16'h0, request_latch_o);
        m = 4'h0;
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            op(3'h4, seed[9:4], seed[3:0]);
            chk("acc", m, acc_o);
            chk("mask", seed[3:0], source_enable_mask_o);
            m = seed[3:0];
        end
        $display("test swap done");
        for (k = 0; k < 6; k = k + 1) begin
            op(3'h2, 6'h3F, 4'h0);
            op(3'h4, 6'h3F, mask_for(k));
            raise(k);
            wait_on(2);
            chk("pend", 16'h0, pending_o);
            op(3'h1, 6'h3F, 4'h0);
            wait_on(0);
            chk("entry", 16'h000C - 16'h0002 * k[15:0], entry_addr_o);
            repeat (5) @(posedge ref_clk_i);
            #1 chk("latch", 16'h0, request_latch_o);
            chk("enable", 16'h0, master_enable_o);
            op(3'h5, 6'h3F, 4'h0);
            wait_on(1);
            @(posedge ref_clk_i);
            #1 chk("enable", 16'h1, master_enable_o);
            $display("test source %0d done", k);
        end
        op(3'h2, 6'h3F, 4'h0);
        op(3'h4, 6'h3F, 4'hF);
        for (k = 0; k < 6; k = k + 1)
            raise(k);
        repeat (8) @(negedge ref_clk_i);
        chk("latch", 16'h3F, request_latch_o);
        op(3'h1, 6'h3F, 4'h0);
        wait_on(0);
        chk("entry", 16'h0002, entry_addr_o);
        op(3'h5, 6'h3F, 4'h0);
        wait_on(0);
        chk("entry", 16'h0004, entry_addr_o);
        repeat (6) @(negedge ref_clk_i);
        chk("latch", 16'h0F, request_latch_o);
        op(3'h3, 6'h08, 4'h0);
        chk("latch", 16'h08, request_latch_o);
        op(3'h2, 6'h00, 4'h0);
        chk("latch", 16'h0, request_latch_o);
        $display("test priority done");
        test_done;
    end
endmodule // prioritized_interrupt_controller_test
